// ==== inc/lfs_cfg.svh ====
`ifndef LFS_CFG_SVH
`define LFS_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LFS_OFS_CTRL      8'h00
`define LFS_OFS_CURR      8'h04
`define LFS_OFS_VOUT      8'h08
`define LFS_OFS_STAT      8'h0c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LFS_CURR_DC_LSB   0
`define LFS_CURR_FL_LSB   8
`define LFS_STAT_TO_BIT   0
`define LFS_STAT_FL_BIT   1
`define LFS_STAT_DN_BIT   2
`define LFS_STAT_HC_BIT   3
`define LFS_STAT_CUR_LSB  8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LFS_RST_CTRL      11'h0e0
`define LFS_RST_CURR      5'h00
`define LFS_RST_VOUT      4'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LFS_CLK_MHZ       125
`define LFS_WDOG_MS       13000
`define LFS_T_RISE_DD_NS  12000
`define LFS_T_STEP_FAST_NS 500
`define LFS_FLASH_UNIT_US 32000
`define LFS_STEP_DD_UA40  1100
`define LFS_STEP_HC_UA40  2475

`endif

// ==== inc/lfs_pkg.sv ====
package lfs_pkg;

   typedef enum logic [1:0] {
      LFS_MODE_SHUT  = 2'h0,
      LFS_MODE_DC    = 2'h1,
      LFS_MODE_FLASH = 2'h2,
      LFS_MODE_VM    = 2'h3
   } lfs_mode_t;

   typedef enum logic [2:0] {
      LFS_ST_IDLE  = 3'h1,
      LFS_ST_LEVEL = 3'h2,
      LFS_ST_SHOT  = 3'h4
   } lfs_fsm_t;

   typedef struct packed {
      logic [2:0] flash_timeout_select;
      logic [2:0] led_sink_enables;
      logic       power_save_enable;
      logic       software_flash_trigger;
      logic       strobe_trigger_type;
      lfs_mode_t  mode;
   } lfs_ctrl_t;

endpackage : lfs_pkg

// ==== hdl/lfs_ctrl.sv ====
// Contract
// - mode 00 means shutdown, every LED sink and the converter off.
// - mode 01 ignores strobe A and trigger bit, drives DC-light current.
// - DC-light without strobe B shuts down unless mode rewritten within 13.0s.
// - strobe B held high keeps the DC-light watchdog disabled.
// - mode 10 enables strobes; flash starts from them or trigger bit with A high.
// - flash-ready switches LEDs by strobes, safety timer armed, watchdog off.
// - mode 11 regulates voltage by code, sinks off, LEDs cut, timer off.
// - level type drives flash current while strobe high, limited by timeout.
// - level timer starts on rising edge, stops on strobe low or timeout.
// - one-shot starts on strobe edge or trigger rise, A high and B low.
// - a running one-shot ignores all triggers and ends at timeout or when mode leaves 10.
// - a one-shot timeout clears the software trigger bit.
// - current moves in steps; up 12us direct, 0.5us high-current; down 0.5us.
// - high-current settings equal direct-drive values times 2.25.
// - power-save bit toggles pulse skipping; down-conversion forces it on.
// - voltage mode enters down-conversion at vin>=vout, leaves 200mV below.
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "lfs_cfg.svh"

module lfs_ctrl
   import lfs_pkg::*;
#(
   parameter logic [31:0] WDOG_CYC       = 32'((64'd`LFS_WDOG_MS * 64'd1000 * 64'd`LFS_CLK_MHZ)),
   parameter logic [31:0] FLASH_UNIT_CYC = 32'((64'd`LFS_FLASH_UNIT_US * 64'd`LFS_CLK_MHZ)),
   parameter int          CODE_W         = 5
) (
   input  wire logic               clk_sys_in,
   input  wire logic               rst_n_in,
   input  wire logic               wb_cyc_in,
   input  wire logic               wb_stb_in,
   input  wire logic               wb_we_in,
   input  wire logic [7:0]         wb_adr_in,
   input  wire logic [3:0]         wb_sel_in,
   input  wire logic [31:0]        wb_dat_in,
   output logic      [31:0]        wb_dat_out,
   output logic                    wb_ack_out,
   input  wire logic               sync_strobe_a_in,
   input  wire logic               sync_strobe_b_in,
   input  wire logic               high_current_select_in,
   input  wire logic               vin_reaches_vout_in,
   input  wire logic               vin_below_vout_in,
   output logic                    converter_en_out,
   output logic                    voltage_mode_out,
   output logic      [3:0]         output_voltage_code_out,
   output logic      [2:0]         led_sink_en_out,
   output logic      [16:0]        led_current_out,
   output logic                    flash_active_out,
   output logic                    power_save_out,
   output logic                    down_conv_out
);

   // ----------------------------------------------------------------
   // timing derived from the clock rate
   // ----------------------------------------------------------------
   localparam logic [10:0] RISE_DD_CYC = 11'((`LFS_T_RISE_DD_NS * `LFS_CLK_MHZ + 999) / 1000);
   localparam logic [10:0] STEP_FAST_CYC = 11'((`LFS_T_STEP_FAST_NS * `LFS_CLK_MHZ + 999) / 1000);

   function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : apply_sel

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [4:0]       sync1_ff;
   logic [4:0]       sync2_ff;
   logic [4:0]       sync3_ff;
   logic [4:0]       filt_ff;
   logic [4:0]       agree;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_ff <= 5'h00;
         sync2_ff <= 5'h00;
         sync3_ff <= 5'h00;
      end else begin
         sync1_ff <= {vin_below_vout_in, vin_reaches_vout_in, high_current_select_in,
                      sync_strobe_b_in, sync_strobe_a_in};
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // a change is taken only once the last two stages agree
   assign agree = ~(sync2_ff ^ sync3_ff);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         filt_ff <= 5'h00;
      end else begin
         filt_ff <= (filt_ff & ~agree) | (sync3_ff & agree);
      end
   end

   logic             strb_a;
   logic             strb_b;
   logic             high_current_select;
   logic             vin_ge;
   logic             vin_low;
   logic             strb_a_prev_ff;

   assign strb_a  = filt_ff[0];
   assign strb_b  = filt_ff[1];
   assign high_current_select  = filt_ff[2];
   assign vin_ge  = filt_ff[3];
   assign vin_low = filt_ff[4];

   // ----------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------
   lfs_ctrl_t        ctrl_ff;
   logic [CODE_W-1:0] dc_code_ff;
   logic [CODE_W-1:0] fl_code_ff;
   logic [3:0]       vout_ff;
   logic             to_flag_ff;
   logic             down_ff;
   logic [CODE_W-1:0] cur_code_ff;
   lfs_fsm_t         fsm_ff;
   logic             ack_ff;
   logic [31:0]      rdat_ff;
   logic             wb_req;
   logic             wr_ctrl;
   logic             wr_curr;
   logic             wr_vout;
   logic             wr_stat;
   logic [31:0]      ctrl_wr_val;
   logic [31:0]      curr_wr_val;
   logic [31:0]      curr_word;
   logic [31:0]      stat_word;
   lfs_ctrl_t        ctrl_new;

   assign wb_req  = wb_cyc_in & wb_stb_in & ~ack_ff;
   assign wr_ctrl = wb_req & wb_we_in & (wb_adr_in == `LFS_OFS_CTRL);
   assign wr_curr = wb_req & wb_we_in & (wb_adr_in == `LFS_OFS_CURR);
   assign wr_vout = wb_req & wb_we_in & (wb_adr_in == `LFS_OFS_VOUT);
   assign wr_stat = wb_req & wb_we_in & (wb_adr_in == `LFS_OFS_STAT);

   assign ctrl_wr_val = apply_sel({21'h000000, ctrl_ff}, wb_dat_in, wb_sel_in);
   assign ctrl_new    = lfs_ctrl_t'(ctrl_wr_val[10:0]);
   assign curr_wr_val = apply_sel(curr_word, wb_dat_in, wb_sel_in);

   always_comb begin
      curr_word = 32'h00000000;
      curr_word[`LFS_CURR_DC_LSB +: CODE_W] = dc_code_ff;
      curr_word[`LFS_CURR_FL_LSB +: CODE_W] = fl_code_ff;
      stat_word = 32'h00000000;
      stat_word[`LFS_STAT_TO_BIT] = to_flag_ff;
      stat_word[`LFS_STAT_FL_BIT] = (fsm_ff != LFS_ST_IDLE);
      stat_word[`LFS_STAT_DN_BIT] = down_ff;
      stat_word[`LFS_STAT_HC_BIT] = high_current_select;
      stat_word[`LFS_STAT_CUR_LSB +: CODE_W] = cur_code_ff;
   end

   // one wait-free cycle: ack rises the edge after the request, unmapped reads zero
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h00000000;
      end else begin
         ack_ff <= wb_req;
         if (wb_req && !wb_we_in) begin
            case (wb_adr_in)
               `LFS_OFS_CTRL: rdat_ff <= {21'h000000, ctrl_ff};
               `LFS_OFS_CURR: rdat_ff <= curr_word;
               `LFS_OFS_VOUT: rdat_ff <= {28'h0000000, vout_ff};
               `LFS_OFS_STAT: rdat_ff <= stat_word;
               default:       rdat_ff <= 32'h00000000;
            endcase
         end
      end
   end

   assign wb_ack_out = ack_ff;
   assign wb_dat_out = rdat_ff;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dc_code_ff <= `LFS_RST_CURR;
         fl_code_ff <= `LFS_RST_CURR;
         vout_ff    <= `LFS_RST_VOUT;
      end else begin
         if (wr_curr) begin
            dc_code_ff <= curr_wr_val[`LFS_CURR_DC_LSB +: CODE_W];
            fl_code_ff <= curr_wr_val[`LFS_CURR_FL_LSB +: CODE_W];
         end
         if (wr_vout && wb_sel_in[0]) begin
            vout_ff <= wb_dat_in[3:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // watchdog and flash timer
   // ----------------------------------------------------------------
   logic [31:0]      wdog_cnt_ff;
   logic             wdog_hit;
   logic             mode_wr_dc;
   logic [31:0]      flash_tmr_ff;
   logic [31:0]      flash_lim;
   logic             flash_exp;
   logic             in_flash;

   assign mode_wr_dc = wr_ctrl && wb_sel_in[0] && (ctrl_new.mode == LFS_MODE_DC);
   assign wdog_hit   = (ctrl_ff.mode == LFS_MODE_DC) && !strb_b && (wdog_cnt_ff == WDOG_CYC - 32'd1);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wdog_cnt_ff <= 32'h00000000;
      end else if (mode_wr_dc || ctrl_ff.mode != LFS_MODE_DC || strb_b) begin
         wdog_cnt_ff <= 32'h00000000;
      end else if (!wdog_hit) begin
         wdog_cnt_ff <= wdog_cnt_ff + 32'd1;
      end
   end

   // timeout is (select + 1) units; the unit scales with the oscillator
   assign flash_lim = FLASH_UNIT_CYC * {29'h00000000, ctrl_ff.flash_timeout_select} + FLASH_UNIT_CYC;
   assign in_flash  = (fsm_ff != LFS_ST_IDLE);
   assign flash_exp = in_flash && (flash_tmr_ff >= flash_lim - 32'd1);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flash_tmr_ff <= 32'h00000000;
      end else if (!in_flash || flash_exp) begin
         flash_tmr_ff <= 32'h00000000;
      end else begin
         flash_tmr_ff <= flash_tmr_ff + 32'd1;
      end
   end

   // ----------------------------------------------------------------
   // flash sequencer
   // ----------------------------------------------------------------
   logic             sft_prev_ff;
   logic             a_rise;
   logic             sft_rise;
   logic             flash_mode;
   logic             level_start;
   logic             shot_start;
   lfs_fsm_t         nxt_fsm;

   assign a_rise      = strb_a && !strb_a_prev_ff;
   assign sft_rise    = ctrl_ff.software_flash_trigger && !sft_prev_ff;
   assign flash_mode  = (ctrl_ff.mode == LFS_MODE_FLASH);
   assign level_start = flash_mode && !ctrl_ff.strobe_trigger_type &&
                        (a_rise || (sft_rise && strb_a));
   assign shot_start  = flash_mode && ctrl_ff.strobe_trigger_type && strb_a && !strb_b &&
                        (a_rise || sft_rise);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         strb_a_prev_ff <= 1'b0;
         sft_prev_ff    <= 1'b0;
      end else begin
         strb_a_prev_ff <= strb_a;
         sft_prev_ff    <= ctrl_ff.software_flash_trigger;
      end
   end

   always_comb begin
      nxt_fsm = fsm_ff;
      case (fsm_ff)
         LFS_ST_IDLE: begin
            if (level_start) begin
               nxt_fsm = LFS_ST_LEVEL;
            end else if (shot_start) begin
               nxt_fsm = LFS_ST_SHOT;
            end
         end
         LFS_ST_LEVEL: begin
            if (!flash_mode || !strb_a || flash_exp) begin
               nxt_fsm = LFS_ST_IDLE;
            end
         end
         LFS_ST_SHOT: begin
            if (!flash_mode || flash_exp) begin
               nxt_fsm = LFS_ST_IDLE;
            end
         end
         default: nxt_fsm = LFS_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fsm_ff <= LFS_ST_IDLE;
      end else begin
         fsm_ff <= nxt_fsm;
      end
   end

   // timeout flag: set wins over a write-one clear
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         to_flag_ff <= 1'b0;
      end else if (flash_exp) begin
         to_flag_ff <= 1'b1;
      end else if (wr_stat && wb_sel_in[0] && wb_dat_in[`LFS_STAT_TO_BIT]) begin
         to_flag_ff <= 1'b0;
      end
   end

   // control word: a software write wins over the hardware clears
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_ff <= lfs_ctrl_t'(`LFS_RST_CTRL);
      end else if (wr_ctrl) begin
         ctrl_ff <= ctrl_new;
      end else begin
         if (wdog_hit) begin
            ctrl_ff.mode <= LFS_MODE_SHUT;
         end
         if (fsm_ff == LFS_ST_SHOT && flash_exp) begin
            ctrl_ff.software_flash_trigger <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // current ramp
   // ----------------------------------------------------------------
   logic [CODE_W-1:0] tgt_code;
   logic [10:0]      ramp_cnt_ff;
   logic [10:0]      ramp_int;
   logic [16:0]      step_ua40;

   always_comb begin
      case (ctrl_ff.mode)
         LFS_MODE_DC:    tgt_code = dc_code_ff;
         LFS_MODE_FLASH: tgt_code = in_flash ? fl_code_ff : '0;
         default:        tgt_code = '0;
      endcase
   end

   // rising steps are slow only in direct drive; falling is always fast
   assign ramp_int = (cur_code_ff < tgt_code && !high_current_select) ? RISE_DD_CYC : STEP_FAST_CYC;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ramp_cnt_ff <= 11'h000;
         cur_code_ff <= '0;
      end else if (ctrl_ff.mode == LFS_MODE_SHUT || ctrl_ff.mode == LFS_MODE_VM) begin
         ramp_cnt_ff <= 11'h000;
         cur_code_ff <= '0;
      end else if (cur_code_ff == tgt_code) begin
         ramp_cnt_ff <= 11'h000;
      end else if (ramp_cnt_ff >= ramp_int - 11'd1) begin
         ramp_cnt_ff <= 11'h000;
         cur_code_ff <= (cur_code_ff < tgt_code) ? cur_code_ff + 1'b1 : cur_code_ff - 1'b1;
      end else begin
         ramp_cnt_ff <= ramp_cnt_ff + 11'd1;
      end
   end

   // units of 25 uA keep the 2.25 ratio exact
   assign step_ua40 = high_current_select ? 17'd`LFS_STEP_HC_UA40 : 17'd`LFS_STEP_DD_UA40;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         led_current_out <= 17'h00000;
      end else begin
         led_current_out <= 17'(step_ua40 * {12'h000, cur_code_ff});
      end
   end

   // ----------------------------------------------------------------
   // voltage mode, down conversion, power save
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         down_ff <= 1'b0;
      end else if (ctrl_ff.mode != LFS_MODE_VM || vin_low) begin
         down_ff <= 1'b0;
      end else if (vin_ge) begin
         down_ff <= 1'b1;
      end
   end

   // output code above ~5.3V with down conversion is the host's concern
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         converter_en_out        <= 1'b0;
         voltage_mode_out        <= 1'b0;
         output_voltage_code_out <= 4'h0;
         led_sink_en_out         <= 3'h0;
         flash_active_out        <= 1'b0;
         power_save_out          <= 1'b0;
         down_conv_out           <= 1'b0;
      end else begin
         converter_en_out        <= (ctrl_ff.mode != LFS_MODE_SHUT);
         voltage_mode_out        <= (ctrl_ff.mode == LFS_MODE_VM);
         output_voltage_code_out <= vout_ff;
         // open inputs left enabled are the host's to clear
         led_sink_en_out         <= (ctrl_ff.mode == LFS_MODE_DC || flash_mode) ?
                                    ctrl_ff.led_sink_enables : 3'h0;
         flash_active_out        <= in_flash;
         power_save_out          <= ctrl_ff.power_save_enable || down_ff;
         down_conv_out           <= down_ff;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_shot_fire;
      fsm_ff == LFS_ST_IDLE ##1 fsm_ff == LFS_ST_SHOT;
   endsequence

   sequence s_shot_run;
      fsm_ff == LFS_ST_SHOT && flash_mode && !flash_exp;
   endsequence

   // outputs register the mode of the cycle before, so look one edge on only
   a_shut_quiet : assert property (ctrl_ff.mode == LFS_MODE_SHUT |=> cur_code_ff == '0 &&
                  !converter_en_out && led_sink_en_out == 3'h0)
      else $error("shutdown left sinks or converter on");
   a_dc_no_flash : assert property ((ctrl_ff.mode == LFS_MODE_DC)[*2] |-> fsm_ff == LFS_ST_IDLE)
      else $error("flash ran in dc-light mode");
   a_wdog_trip : assert property (wdog_hit && !wr_ctrl |=> ctrl_ff.mode == LFS_MODE_SHUT)
      else $error("watchdog expiry did not shut down");
   a_wdog_off : assert property (strb_b |=> wdog_cnt_ff == 32'h00000000)
      else $error("watchdog counted with strobe b high");
   a_wdog_restart : assert property (mode_wr_dc |=> wdog_cnt_ff == 32'h00000000)
      else $error("mode write did not restart watchdog");
   a_level_go : assert property (fsm_ff == LFS_ST_IDLE && level_start |=> fsm_ff == LFS_ST_LEVEL)
      else $error("level strobe did not start flash");
   a_level_stop : assert property (fsm_ff == LFS_ST_LEVEL && !strb_a |=> fsm_ff == LFS_ST_IDLE)
      else $error("level flash outlived strobe");
   a_vm_sinks : assert property (ctrl_ff.mode == LFS_MODE_VM |=> led_sink_en_out == 3'h0 &&
                fsm_ff == LFS_ST_IDLE)
      else $error("voltage mode left sinks on");
   a_shot_hold : assert property (s_shot_run |=> fsm_ff == LFS_ST_SHOT)
      else $error("one-shot ended before timeout");
   a_shot_timer : assert property (s_shot_fire |-> flash_tmr_ff == 32'h00000000)
      else $error("one-shot timer did not start at zero");
   a_sft_clear : assert property (fsm_ff == LFS_ST_SHOT && flash_exp && !wr_ctrl |=>
                 !ctrl_ff.software_flash_trigger)
      else $error("trigger bit survived one-shot timeout");
   a_down_exit : assert property (ctrl_ff.mode != LFS_MODE_VM |=> !down_ff)
      else $error("down conversion outside voltage mode");
   a_psm_force : assert property (down_ff |=> power_save_out)
      else $error("down conversion without power save");

endmodule : lfs_ctrl

// ==== verif/lfs_cam_model.sv ====
`timescale 1ns/1ps
module lfs_cam_model (
   input  wire logic        clk_sys_in,
   input  wire logic        fire_in,
   input  wire logic [15:0] width_in,
   input  wire logic        wdog_hold_in,
   output logic             sync_strobe_a_out,
   output logic             sync_strobe_b_out
);
   // ------------------------------------------------
   // strobe a pulse of given width, b as a level
   // ------------------------------------------------
   logic [15:0] left_ff = 16'h0000;
   always_ff @(posedge clk_sys_in) begin
      if (fire_in) begin
         left_ff <= width_in;
      end else if (left_ff != 16'h0000) begin
         left_ff <= left_ff - 16'h0001;
      end
   end
   assign sync_strobe_a_out = (left_ff != 16'h0000);
   assign sync_strobe_b_out = wdog_hold_in;
endmodule : lfs_cam_model

// ==== verif/led_flash_mode_strobe_control_tb.sv ====
`timescale 1ns/1ps
`include "lfs_cfg.svh"
module led_flash_mode_strobe_control_tb;
   logic clk, rst_n, cyc, stb, we, hc, vr, vb, fire, hold_b, sa, sb, ack, cen, vm, fa, ps, dn;
   logic [7:0] adr;
   logic [31:0] dat, dout, rd;
   logic [3:0] vc, vco;
   logic [2:0] sinks;
   logic [16:0] cur;
   logic [15:0] wid;
   logic [4:0] code;
   int mismatches, checks_done, tmo;
   lfs_ctrl #(.WDOG_CYC(32'd200), .FLASH_UNIT_CYC(32'd20)) dut (.clk_sys_in(clk), .rst_n_in(rst_n),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
      .wb_dat_in(dat), .wb_dat_out(dout), .wb_ack_out(ack), .sync_strobe_a_in(sa),
      .sync_strobe_b_in(sb), .high_current_select_in(hc), .vin_reaches_vout_in(vr),
      .vin_below_vout_in(vb), .converter_en_out(cen), .voltage_mode_out(vm),
      .output_voltage_code_out(vco), .led_sink_en_out(sinks), .led_current_out(cur),
      .flash_active_out(fa), .power_save_out(ps), .down_conv_out(dn));
   lfs_cam_model cam (.clk_sys_in(clk), .fire_in(fire), .width_in(wid), .wdog_hold_in(hold_b),
      .sync_strobe_a_out(sa), .sync_strobe_b_out(sb));
   function automatic logic [31:0] exp_cur(input logic [4:0] c, input logic h);
      return h ? 32'(c) * 32'd2475 : 32'(c) * 32'd1100;
   endfunction : exp_cur
   task automatic stop_test();
      if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic strobe(input logic [15:0] w);
      fire <= 1'b1;
      wid <= w;
      @(posedge clk);
      fire <= 1'b0;
   endtask : strobe
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      tmo++;
      if (tmo == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   initial begin
      {rst_n, cyc, stb, we, hc, vr, vb, fire, hold_b} = '0;
      {adr, dat, wid, mismatches, checks_done, tmo} = '0;
      void'($urandom(53));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      wb(1'b0, `LFS_OFS_CTRL, 32'h0);
      chk(rd, 32'h0e0);
      chk(32'(cen), 32'h0);
      // ------------------------------------------------
      // dc light, high current, watchdog held off, then left to expire
      // ------------------------------------------------
      code = 5'($urandom_range(1, 7));
      hc <= 1'b1;
      hold_b <= 1'b1;
      wb(1'b1, `LFS_OFS_CURR, 32'(code));
      wb(1'b1, `LFS_OFS_CTRL, 32'h21);
      strobe(16'd40);
      repeat (20) @(posedge clk);
      chk(32'(fa), 32'h0);
      repeat (64 * int'(code) + 60) @(posedge clk);
      chk(32'(cur), exp_cur(code, 1'b1));
      repeat (200) @(posedge clk);
      wb(1'b0, `LFS_OFS_CTRL, 32'h0);
      chk(rd & 32'h3, 32'h1);
      hold_b <= 1'b0;
      repeat (10) @(posedge clk);
      wb(1'b1, `LFS_OFS_CTRL, 32'h21);
      repeat (150) @(posedge clk);
      wb(1'b1, `LFS_OFS_CTRL, 32'h21);
      repeat (150) @(posedge clk);
      wb(1'b0, `LFS_OFS_CTRL, 32'h0);
      chk(rd & 32'h3, 32'h1);
      repeat (100) @(posedge clk);
      wb(1'b0, `LFS_OFS_CTRL, 32'h0);
      chk(rd & 32'h3, 32'h0);
      // ------------------------------------------------
      // level flash: short pulse, then one past timeout
      // ------------------------------------------------
      wb(1'b1, `LFS_OFS_CTRL, 32'h3e2);
      strobe(16'd30);
      repeat (12) @(posedge clk);
      chk(32'(fa), 32'h1);
      repeat (40) @(posedge clk);
      wb(1'b0, `LFS_OFS_STAT, 32'h0);
      chk(rd & 32'h1, 32'h0);
      chk(32'(fa), 32'h0);
      wb(1'b1, `LFS_OFS_CTRL, 32'h0e2);
      strobe(16'd300);
      repeat (60) @(posedge clk);
      wb(1'b0, `LFS_OFS_STAT, 32'h0);
      chk(rd & 32'h1, 32'h1);
      repeat (250) @(posedge clk);
      // ------------------------------------------------
      // one-shot from edge, then from software trigger
      // ------------------------------------------------
      wb(1'b1, `LFS_OFS_CTRL, 32'h1e6);
      strobe(16'd400);
      repeat (12) @(posedge clk);
      chk(32'(fa), 32'h1);
      repeat (90) @(posedge clk);
      chk(32'(fa), 32'h0);
      wb(1'b1, `LFS_OFS_CTRL, 32'h1ee);
      repeat (10) @(posedge clk);
      chk(32'(fa), 32'h1);
      repeat (90) @(posedge clk);
      wb(1'b0, `LFS_OFS_CTRL, 32'h0);
      chk(rd & 32'h8, 32'h0);
      // ------------------------------------------------
      // voltage mode and down conversion
      // ------------------------------------------------
      vc = 4'($urandom_range(0, 8));
      wb(1'b1, `LFS_OFS_VOUT, 32'(vc));
      wb(1'b1, `LFS_OFS_CTRL, 32'h0e3);
      vr <= 1'b1;
      repeat (10) @(posedge clk);
      chk({vm, sinks, vco, cur}, {1'b1, 3'h0, vc, 17'h0});
      chk({dn, ps}, 32'h3);
      vr <= 1'b0;
      vb <= 1'b1;
      repeat (10) @(posedge clk);
      chk({dn, ps}, 32'h0);
      wb(1'b1, `LFS_OFS_CTRL, 32'h0e0);
      repeat (3) @(posedge clk);
      chk({cen, sinks}, 32'h0);
      stop_test();
   end
endmodule : led_flash_mode_strobe_control_tb
